// file: rtl/multicast_hash_filter_regs.sv
/*
 multicast hash filter register group: head frame length mirror, four hash
 table words with crc-32 lookup on group destination addresses, identity word
 with switch start bit, and a bank select register.
 assumes a host writing and reading one cycle per strobe, and a receive queue
 presenting the head frame byte-count word and a valid flag synchronously.
*/
`timescale 1ns/1ps
`default_nettype none

module multicast_hash_filter_regs (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire hash_filter_pkg::reg_req_t req_i,
   output logic [15:0] rdata_o,
   input wire logic [15:0] head_count_word_i,
   input wire logic head_frame_valid_i,
   input wire hash_filter_pkg::frame_req_t frame_i,
   output hash_filter_pkg::frame_verdict_t verdict_o,
   output logic switch_enable_o
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HASH = 3'b010,
      ST_DONE = 3'b100
   } hash_state_t;

   logic [15:0] hash_word_q [hash_filter_pkg::HASH_WORDS];
   logic [5:0] bank_q;
   logic start_q;
   logic accept_every_frame_q;
   logic accept_every_group_frame_q;
   logic [15:0] rdata_q;
   hash_state_t state_q;
   logic [31:0] crc_q;
   logic [47:0] da_q;
   logic [2:0] byte_cnt_q;
   logic frame_group_q;
   hash_filter_pkg::frame_verdict_t verdict_q;
   logic [hash_filter_pkg::LEN_W-1:0] frame_len_q;

   logic [hash_filter_pkg::HASH_IDX_W-1:0] hash_idx;
   logic [31:0] crc_d;
   logic table_bit;
   logic bank_reserved;

   // reserved banks decode nothing but bank select
   assign bank_reserved = (bank_q >= hash_filter_pkg::BANK_RSVD_LO) &&
                          (bank_q <= hash_filter_pkg::BANK_RSVD_HI);

   // bank select, reachable at the same offset in every bank
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         bank_q <= hash_filter_pkg::BANK_RST;
      end else if (req_i.wr && req_i.addr == hash_filter_pkg::OFS_BANK_SEL) begin
         bank_q <= req_i.wdata[5:0];
      end
   end

   // hash table words
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < hash_filter_pkg::HASH_WORDS; i++) begin
            hash_word_q[i] <= hash_filter_pkg::HASH_RST;
         end
      end else if (req_i.wr && bank_q == hash_filter_pkg::BANK_HASH) begin
         case (req_i.addr)
            hash_filter_pkg::OFS_HASH_0: hash_word_q[0] <= req_i.wdata;
            hash_filter_pkg::OFS_HASH_1: hash_word_q[1] <= req_i.wdata;
            hash_filter_pkg::OFS_HASH_2: hash_word_q[2] <= req_i.wdata;
            hash_filter_pkg::OFS_HASH_3: hash_word_q[3] <= req_i.wdata;
            default: ;
         endcase
      end
   end

   // start bit; identity fields above it ignore writes
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         start_q <= 1'b0;
      end else if (req_i.wr && bank_q == hash_filter_pkg::BANK_SWITCH &&
                   req_i.addr == hash_filter_pkg::OFS_IDENTITY) begin
         start_q <= req_i.wdata[0];
      end
   end

   // receive control bits, kept locally so the filter can bypass the table
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         accept_every_frame_q <= 1'b0;
         accept_every_group_frame_q <= 1'b0;
      end else if (req_i.wr && bank_q == hash_filter_pkg::BANK_RX &&
                   req_i.addr == hash_filter_pkg::OFS_RX_CTRL) begin
         accept_every_frame_q <= req_i.wdata[hash_filter_pkg::RXC_ALL_BIT];
         accept_every_group_frame_q <= req_i.wdata[hash_filter_pkg::RXC_GROUP_BIT];
      end
   end

   // length mirror follows the head frame only while it is complete
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         frame_len_q <= '0;
      end else if (head_frame_valid_i) begin
         frame_len_q <= head_count_word_i[hash_filter_pkg::LEN_W-1:0];
      end
   end

   // read mux, data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         rdata_q <= 16'h0000;
      end else if (req_i.rd) begin
         rdata_q <= 16'h0000;
         if (req_i.addr == hash_filter_pkg::OFS_BANK_SEL) begin
            rdata_q <= {10'h000, bank_q};
         end else if (!bank_reserved) begin
            case (bank_q)
               hash_filter_pkg::BANK_RX: begin
                  if (req_i.addr == hash_filter_pkg::OFS_FRAME_LEN) begin
                     // upper five bits reserved, read zero
                     rdata_q <= {5'h00, frame_len_q};
                  end else if (req_i.addr == hash_filter_pkg::OFS_RX_CTRL) begin
                     rdata_q <= {14'h0000, accept_every_group_frame_q,
                                 accept_every_frame_q};
                  end
               end
               hash_filter_pkg::BANK_HASH: begin
                  case (req_i.addr)
                     hash_filter_pkg::OFS_HASH_0: rdata_q <= hash_word_q[0];
                     hash_filter_pkg::OFS_HASH_1: rdata_q <= hash_word_q[1];
                     hash_filter_pkg::OFS_HASH_2: rdata_q <= hash_word_q[2];
                     hash_filter_pkg::OFS_HASH_3: rdata_q <= hash_word_q[3];
                     default: rdata_q <= 16'h0000;
                  endcase
               end
               hash_filter_pkg::BANK_SWITCH: begin
                  if (req_i.addr == hash_filter_pkg::OFS_IDENTITY) begin
                     rdata_q <= {hash_filter_pkg::FAMILY_CODE, hash_filter_pkg::CHIP_CODE,
                                 hash_filter_pkg::REV_CODE, start_q};
                  end
               end
               default: rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   // one byte of reflected crc-32, lsb first as the bits go on the wire
   function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] b);
      logic [31:0] c;
      c = crc;
      for (int k = 0; k < 8; k++) begin
         if (c[31] ^ b[k]) begin
            c = {c[30:0], 1'b0} ^ hash_filter_pkg::CRC_POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      return c;
   endfunction

   // first destination byte sits in the top of the 48-bit field
   assign crc_d = crc_byte(crc_q, da_q[47:40]);
   assign hash_idx = crc_q[31:26];
   assign table_bit = hash_word_q[hash_idx[5:4]][hash_idx[3:0]];

   // hash walk, one byte per cycle; a group frame has bit 0 of byte 0 set
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         state_q <= ST_IDLE;
         crc_q <= hash_filter_pkg::CRC_INIT;
         da_q <= 48'h0000_0000_0000;
         byte_cnt_q <= 3'h0;
         frame_group_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (frame_i.valid) begin
                  da_q <= frame_i.dest_addr;
                  frame_group_q <= frame_i.dest_addr[40];
                  crc_q <= hash_filter_pkg::CRC_INIT;
                  byte_cnt_q <= 3'h0;
                  state_q <= ST_HASH;
               end
            end
            ST_HASH: begin
               crc_q <= crc_d;
               da_q <= {da_q[39:0], 8'h00};
               byte_cnt_q <= byte_cnt_q + 3'h1;
               if (byte_cnt_q == 3'(hash_filter_pkg::DA_BYTES - 1)) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // verdict; unicast frames are not this filter's business and pass
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         verdict_q <= '0;
      end else begin
         verdict_q.valid <= (state_q == ST_DONE);
         if (state_q == ST_DONE) begin
            if (!frame_group_q || accept_every_frame_q || accept_every_group_frame_q) begin
               verdict_q.accept <= 1'b1;
            end else begin
               verdict_q.accept <= table_bit;
            end
         end
      end
   end

   // switch enable output mirrors the start bit
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         switch_enable_o <= 1'b0;
      end else begin
         switch_enable_o <= start_q;
      end
   end

   assign rdata_o = rdata_q;
   assign verdict_o = verdict_q;

endmodule // multicast_hash_filter_regs

`default_nettype wire

// file: shared/hash_filter_pkg.sv
/*
 holds register offsets, bank numbers, field positions, reset values and bus
 carriers for the multicast hash filter register group.
 assumes a banked 16-bit register space addressed by bank select plus offset.
*/
`default_nettype none

package hash_filter_pkg;

   // banks and offsets
   localparam logic [5:0] BANK_RX = 6'h12;
   localparam logic [5:0] BANK_HASH = 6'h13;
   localparam logic [5:0] BANK_RSVD_LO = 6'h14;
   localparam logic [5:0] BANK_RSVD_HI = 6'h1F;
   localparam logic [5:0] BANK_SWITCH = 6'h20;
   localparam logic [3:0] OFS_HASH_0 = 4'h0;
   localparam logic [3:0] OFS_HASH_1 = 4'h2;
   localparam logic [3:0] OFS_HASH_2 = 4'h4;
   localparam logic [3:0] OFS_HASH_3 = 4'h6;
   localparam logic [3:0] OFS_FRAME_LEN = 4'h6;
   localparam logic [3:0] OFS_IDENTITY = 4'h0;
   localparam logic [3:0] OFS_BANK_SEL = 4'hE;
   localparam logic [3:0] OFS_RX_CTRL = 4'hC;

   // field layout
   localparam int LEN_W = 11;
   localparam int HASH_IDX_W = 6;
   localparam int HASH_WORDS = 4;
   localparam int RXC_ALL_BIT = 0;
   localparam int RXC_GROUP_BIT = 1;

   // reset values
   localparam logic [15:0] HASH_RST = 16'h0000;
   localparam logic [5:0] BANK_RST = 6'h00;

   // identity values, arbitrary neutral codes
   localparam logic [7:0] FAMILY_CODE = 8'h5A;
   localparam logic [3:0] CHIP_CODE = 4'h3;
   localparam logic [2:0] REV_CODE = 3'h2;

   // crc-32
   localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam int DA_BYTES = 6;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [47:0] dest_addr;
   } frame_req_t;

   typedef struct packed {
      logic valid;
      logic accept;
   } frame_verdict_t;

endpackage

`default_nettype wire

// file: verification/hash_filter_props.sv
/*
 checker for the multicast hash filter register group, bound to its top.
 assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hash_filter_chk (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire hash_filter_pkg::reg_req_t req_i,
   input wire logic [15:0] rdata_o,
   input wire logic [15:0] head_count_word_i,
   input wire logic head_frame_valid_i,
   input wire hash_filter_pkg::frame_req_t frame_i,
   input wire hash_filter_pkg::frame_verdict_t verdict_o,
   input wire logic switch_enable_o
);
   logic [5:0] bank_q;
   logic [1:0] ctrl_q;
   logic [2:0] busy_q;
   logic take_w;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // a frame is only taken while the engine is idle
   assign take_w = frame_i.valid && busy_q == 3'h0;
   // shadow of bank select and bypass bits, needed to decode accesses
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         bank_q <= hash_filter_pkg::BANK_RST;
         ctrl_q <= 2'h0;
      end else if (req_i.wr && req_i.addr == hash_filter_pkg::OFS_BANK_SEL) begin
         bank_q <= req_i.wdata[5:0];
      end else if (req_i.wr && bank_q == 6'h12 && req_i.addr == 4'hC) begin
         ctrl_q <= req_i.wdata[1:0];
      end
   end
   // engine occupancy: seven busy cycles after a take
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) busy_q <= 3'h0;
      else if (take_w) busy_q <= 3'h7;
      else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
   end
   sequence s_len_read;
      req_i.rd && bank_q == 6'h12 && req_i.addr == hash_filter_pkg::OFS_FRAME_LEN;
   endsequence
   sequence s_id_read;
      req_i.rd && bank_q == 6'h20 && req_i.addr == hash_filter_pkg::OFS_IDENTITY;
   endsequence
   sequence s_id_write;
      req_i.wr && bank_q == 6'h20 && req_i.addr == hash_filter_pkg::OFS_IDENTITY;
   endsequence
   a_verdict_latency: assert property (take_w |-> ##8 verdict_o.valid)
      else $error("verdict missing eight cycles after a take");
   a_verdict_cause: assert property (verdict_o.valid |-> $past(take_w, 8))
      else $error("verdict without a frame taken eight cycles before");
   a_accept_held: assert property ($changed(verdict_o.accept) |-> verdict_o.valid)
      else $error("accept changed outside a verdict");
   a_bypass_accept: assert property (verdict_o.valid && ctrl_q != 2'h0 |-> verdict_o.accept)
      else $error("group frame dropped while bypass set");
   a_len_reserved: assert property (s_len_read |=> rdata_o[15:11] == 5'h00)
      else $error("length upper bits not zero");
   a_rsvd_bank_zero: assert property (req_i.rd && bank_q >= 6'h14 && bank_q <= 6'h1F
      && req_i.addr != 4'hE |=> rdata_o == 16'h0000)
      else $error("reserved bank read not zero");
   a_id_codes: assert property (s_id_read |=> rdata_o[15:1] == {hash_filter_pkg::FAMILY_CODE,
      hash_filter_pkg::CHIP_CODE, hash_filter_pkg::REV_CODE})
      else $error("identity codes wrong");
   a_start_follows: assert property (s_id_write |-> ##2
      switch_enable_o == $past(req_i.wdata[0], 2))
      else $error("switch enable does not follow start bit");
   a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
      else $error("read data moved without a read");
endmodule // hash_filter_chk
bind multicast_hash_filter_regs hash_filter_chk chk_u (.ref_clk_i, .rstn_i, .req_i, .rdata_o,
   .head_count_word_i, .head_frame_valid_i, .frame_i, .verdict_o, .switch_enable_o);
`default_nettype wire

// file: verification/rx_queue_model.sv
/*
 receive queue model: head frame byte-count word, valid flag and frame offers.
 assumes its tasks are called right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_queue_model (
   input wire logic clk_i,
   output logic [15:0] count_word_o,
   output logic frame_valid_o,
   output hash_filter_pkg::frame_req_t frame_o
);
   logic [15:0] w_q = 16'h0000;
   logic hv_q = 1'b0;
   logic fv_q = 1'b0;
   logic [47:0] da_q = 48'h0000_0000_0000;
   logic [14:0] cnt_q = 15'h0000;
   // the stale count word churns every cycle so a mirror that keeps sampling is caught
   always_ff @(posedge clk_i) cnt_q <= cnt_q + 15'h0001;
   assign count_word_o = hv_q ? w_q : ~w_q ^ {cnt_q, 1'b0};
   assign frame_valid_o = hv_q;
   assign frame_o = {fv_q, fv_q ? da_q : ~da_q};
   // head frame complete (v high) or still arriving (v low)
   task automatic present(input logic [15:0] w, input logic v);
      @(posedge clk_i) w_q <= w;
      hv_q <= v;
   endtask
   // one-cycle frame offer
   task automatic offer(input logic [47:0] a);
      @(posedge clk_i) fv_q <= 1'b1;
      da_q <= a;
      @(posedge clk_i) fv_q <= 1'b0;
   endtask
endmodule // rx_queue_model
`default_nettype wire

// file: verification/tb.sv
/*
 testbench for the multicast hash filter register group.
 assumes the queue model and the bound checker sit beside the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [14:0] ID_C = {hash_filter_pkg::FAMILY_CODE, hash_filter_pkg::CHIP_CODE,
      hash_filter_pkg::REV_CODE};
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   hash_filter_pkg::reg_req_t req_q = '0;
   hash_filter_pkg::frame_req_t fr_w;
   hash_filter_pkg::frame_verdict_t vd_w;
   logic [15:0] rdata_w;
   logic [15:0] cw_w;
   logic hv_w;
   logic sw_w;
   logic [5:0] ix;
   logic [15:0] m;
   logic [47:0] da [4] = '{48'h0100_5E00_00FB, 48'h3333_0000_0001, 48'hFFFF_FFFF_FFFF,
      48'h0180_C200_0000};
   int mismatches = 0;
   int samples_checked = 0;
   int n;
   always #20 ref_clk_i = ~ref_clk_i;
   multicast_hash_filter_regs dut_u (.ref_clk_i, .rstn_i, .req_i(req_q), .rdata_o(rdata_w),
      .head_count_word_i(cw_w), .head_frame_valid_i(hv_w), .frame_i(fr_w), .verdict_o(vd_w),
      .switch_enable_o(sw_w));
   rx_queue_model q_u (.clk_i(ref_clk_i), .count_word_o(cw_w), .frame_valid_o(hv_w),
      .frame_o(fr_w));
   task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   // one request cycle, then one idle cycle so no signal is driven twice at once
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_i) req_q <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk_i) req_q <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
      @(posedge ref_clk_i) req_q <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge ref_clk_i) req_q <= '0;
      #1 chk_word(nm, e, rdata_w);
   endtask
   task automatic sel(input logic [5:0] b);
      wr(hash_filter_pkg::OFS_BANK_SEL, {10'h000, b});
   endtask
   // crc-32 over the address, first byte first, each byte lsb first
   function automatic logic [5:0] hidx(input logic [47:0] a);
      logic [31:0] c;
      logic fb;
      c = hash_filter_pkg::CRC_INIT;
      for (int i = 0; i < 6; i++)
         for (int b = 0; b < 8; b++) begin
            fb = c[31] ^ a[40 - 8 * i + b];
            c = {c[30:0], 1'b0} ^ (fb ? hash_filter_pkg::CRC_POLY : 32'h0000_0000);
         end
      return c[31:26];
   endfunction
   task automatic filt(input logic [47:0] a, input logic e);
      q_u.offer(a);
      #1 n = 0;
      while (vd_w.valid !== 1'b1 && n < 20) begin
         @(posedge ref_clk_i);
         #1 n++;
      end
      chk_word("verdict", {14'h0000, 1'b1, e}, {14'h0000, vd_w});
   endtask
   task automatic words(input logic [15:0] hit, input logic [15:0] rest);
      for (int i = 0; i < 4; i++) wr(4'(2 * i), (i == ix[5:4]) ? hit : rest);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog: the sequence needs well under two thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      sel(6'h13);
      for (int i = 0; i < 4; i++) rd(4'(2 * i), 16'h0000, "hash_reset");
      for (int i = 0; i < 4; i++) wr(4'(2 * i), 16'hA5C3 ^ 16'(i));
      for (int i = 0; i < 4; i++) rd(4'(2 * i), 16'hA5C3 ^ 16'(i), "hash_rw");
      // every bit but the hashed one set, then only the hashed one
      foreach (da[k]) begin
         ix = hidx(da[k]);
         m = 16'h0001 << ix[3:0];
         words(~m, 16'hFFFF);
         filt(da[k], 1'b0);
         words(m, 16'h0000);
         filt(da[k], 1'b1);
      end
      words(16'h0000, 16'h0000);
      sel(6'h12);
      wr(4'hC, 16'h0001);
      filt(da[0], 1'b1);
      wr(4'hC, 16'h0002);
      filt(da[1], 1'b1);
      wr(4'hC, 16'h0000);
      filt(da[1], 1'b0);
      filt(48'h0200_0000_0001, 1'b1);
      rd(4'hC, 16'h0000, "rx_ctrl_back");
      q_u.present(16'hFFFF, 1'b1);
      rd(hash_filter_pkg::OFS_FRAME_LEN, 16'h07FF, "frame_len");
      q_u.present(16'h0123, 1'b0);
      rd(hash_filter_pkg::OFS_FRAME_LEN, 16'h07FF, "len_hold");
      // reserved banks ignore writes, yet bank select still answers there
      sel(6'h14);
      wr(4'h0, 16'hFFFF);
      rd(4'h0, 16'h0000, "rsvd_lo");
      sel(6'h1F);
      rd(4'h6, 16'h0000, "rsvd_hi");
      rd(hash_filter_pkg::OFS_BANK_SEL, 16'h001F, "rsvd_bank_sel");
      sel(6'h13);
      rd(4'h0, 16'h0000, "hash_untouched");
      sel(6'h20);
      #1 chk_bit("switch_reset", 1'b0, sw_w);
      rd(4'h0, {ID_C, 1'b0}, "identity");
      wr(4'h0, 16'h0001);
      rd(4'h0, {ID_C, 1'b1}, "start_set");
      chk_bit("switch_on", 1'b1, sw_w);
      wr(4'h0, 16'hFFFE);
      rd(4'h0, {ID_C, 1'b0}, "start_clear");
      chk_bit("switch_off", 1'b0, sw_w);
      complete_run();
   end
endmodule // tb
`default_nettype wire
